// ### hdl/lmuc_pkg.sv
// Purpose: Shared constants and types of the LIN mode serial controller.
// Assumes: One 50 MHz clock, all inputs synchronous to it.
// Notes: Bit-time figures are whole bits of the loaded baud interval.
//
// Contract
// - Baud reload is one full bit interval.
// - LIN control written only when select is 010.
// - Slave hardware advances the LIN state field.
// - Break starts after current character, clears itself.
// - Synch byte held until break completes.
// - Prompt write gives exactly the configured stop bits.
// - Sleep: low of 3+ bits flags break detect.
// - Break length reads Fh beyond 15 bits.
// - Wait state: break needs 11+ low bits.
// - Autobaud times 8 synch bits, loads time/8.
// - Measure overflow sets overrun, keeps baud reload.
// - 16-bit measure counter behind 3-bit prescaler.
// - Active state: 10+ low bits returns to autobaud.
// - Wait state issues no receive events.
// - Transmit empty sets on enable, after start bit.
// - Transmit mismatch on bus sets physical layer error.
// - Received break length is four bits.

package lmuc_pkg;

	// ------------------------------------------------------------
	// Encodings
	// ------------------------------------------------------------
	localparam logic [2:0] MODE_SEL_LIN = 3'h2;

	typedef enum logic [1:0] {
		LIN_SLEEP = 2'b00,
		LIN_WAIT = 2'b01,
		LIN_ABAUD = 2'b10,
		LIN_ACTIVE = 2'b11
	} lmuc_lin_e;

	typedef enum logic [2:0] {
		TX_IDLE = 3'b000,
		TX_START = 3'b001,
		TX_DATA = 3'b010,
		TX_STOP = 3'b011,
		TX_BREAK = 3'b100
	} lmuc_tx_e;

	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_START = 2'b01,
		RX_DATA = 2'b10,
		RX_STOP = 2'b11
	} lmuc_rx_e;

	// ------------------------------------------------------------
	// Thresholds and reset values
	// ------------------------------------------------------------
	localparam logic [4:0] WAKE_BITS = 5'h03;
	localparam logic [4:0] ACTIVE_BRK_BITS = 5'h0A;
	localparam logic [4:0] WAIT_BRK_BITS = 5'h0B;
	localparam logic [4:0] LEN_SAT = 5'h0F;
	localparam logic [4:0] LOW_CAP = 5'h10;
	localparam logic [1:0] ABAUD_LAST_EDGE = 2'h3;
	localparam logic [2:0] PRESCALE_TOP = 3'h7;
	localparam logic [15:0] BAUD_RST = 16'h0A2C;
	localparam logic [3:0] BRK_LEN_RST = 4'hD;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic master_select;
		logic slave_select;
		logic autobaud_enable;
		lmuc_lin_e lin_state_field;
		logic [3:0] transmit_break_length;
	} lmuc_ctrl_s;

	typedef struct packed {
		logic break_detect;
		logic overrun_error;
		logic physical_layer_error;
		logic [3:0] received_break_length;
	} lmuc_status_s;

endpackage

// ### hdl/lmuc_top.sv
// Purpose: LIN mode serial controller with transmit FIFO.
// Assumes: Bus line inputs synchronous to ref_clk_in.
// Notes: Control and status are plain ports, no register bus.

`timescale 1ns/1ps

// ----------------------------------------------------------------
// Transmit FIFO
// ----------------------------------------------------------------
module lmuc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_n_in,
	// Fill side
	input wire logic in_valid_in,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic in_ready_out,
	// Drain side
	output logic out_valid_out,
	output logic [WIDTH-1:0] out_data_out,
	input wire logic out_ready_in
);
	localparam int AW = $clog2(DEPTH);

	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_chk
			$error("lmuc_fifo: DEPTH must be a power of two");
		end
	endgenerate

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic [AW:0] next_count;
	logic push;
	logic pop;

	assign push = in_valid_in & in_ready_out;
	assign pop = out_valid_out & out_ready_in;
	assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);
	assign out_data_out = mem[rd_ptr];

	always_ff @(posedge clk_in) begin
		if (push) begin
			mem[wr_ptr] <= in_data_in;
		end
	end

	// Flags registered so ready and valid come from flops
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			in_ready_out <= 1'b0;
			out_valid_out <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + AW'(1);
			end
			if (pop) begin
				rd_ptr <= rd_ptr + AW'(1);
			end
			count <= next_count;
			in_ready_out <= next_count != (AW+1)'(DEPTH);
			out_valid_out <= next_count != '0;
		end
	end
endmodule

// ----------------------------------------------------------------
// Controller
// ----------------------------------------------------------------
module lmuc_top #(
	parameter int FIFO_DEPTH = 16
) (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic reset_n_in,
	// Configuration
	input wire logic [2:0] shared_reg_select_in,
	input wire logic lin_ctrl_wr_in,
	input wire lmuc_pkg::lmuc_ctrl_s lin_ctrl_in,
	input wire logic transmitter_enable_in,
	input wire logic receiver_enable_in,
	input wire logic two_stop_bits_in,
	input wire logic send_break_set_in,
	input wire logic baud_reload_wr_in,
	input wire logic [15:0] baud_reload_in,
	input wire logic status_clear_in,
	// Transmit data
	input wire logic tx_valid_in,
	input wire logic [7:0] tx_data_in,
	output logic tx_ready_out,
	// Bus line
	input wire logic rx_line_in,
	output logic tx_line_out,
	// Receive data
	output logic [7:0] rx_data_out,
	output logic rx_valid_out,
	// Status
	output logic transmit_data_empty_out,
	output logic transmitter_idle_out,
	output logic send_break_out,
	output lmuc_pkg::lmuc_lin_e lin_state_out,
	output lmuc_pkg::lmuc_status_s status_out,
	output logic [15:0] baud_reload_out
);
	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	lmuc_pkg::lmuc_tx_e tx_state;
	lmuc_pkg::lmuc_rx_e rx_state;
	logic master_select;
	logic slave_select;
	logic autobaud_enable;
	logic [3:0] brk_len;
	logic lin_on;
	logic slave;
	logic [15:0] bit_last;
	logic [15:0] bit_half;
	logic fifo_valid;
	logic [7:0] fifo_data;
	logic push;
	logic [15:0] tx_cnt;
	logic [3:0] tx_bits;
	logic [7:0] tx_shift;
	logic tx_bit_end;
	logic stop_last;
	logic brk_last;
	logic tx_launch;
	logic break_go;
	logic brk_done;
	logic tx_en_q;
	logic rx_q;
	logic fall;
	logic rise;
	logic [15:0] low_cnt;
	logic [4:0] low_bits;
	logic wake_hit;
	logic wait_hit;
	logic act_hit;
	logic ab_run;
	logic ab_hold;
	logic [2:0] ab_pre;
	logic [15:0] ab_cnt;
	logic [1:0] ab_edges;
	logic ab_done;
	logic ab_ovf;
	logic [15:0] rx_cnt;
	logic [2:0] rx_bits;
	logic [7:0] rx_shift;
	logic rx_report;
	logic ple_hit;

	// ------------------------------------------------------------
	// Decodes
	// ------------------------------------------------------------
	assign lin_on = master_select | slave_select;
	assign slave = slave_select & ~master_select;
	// Reload is a whole bit, not a sixteenth
	assign bit_last = baud_reload_out - 16'h0001;
	assign bit_half = {1'b0, baud_reload_out[15:1]};
	assign push = tx_valid_in & tx_ready_out;

	lmuc_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_in(ref_clk_in),
		.reset_n_in(reset_n_in),
		.in_valid_in(tx_valid_in),
		.in_data_in(tx_data_in),
		.in_ready_out(tx_ready_out),
		.out_valid_out(fifo_valid),
		.out_data_out(fifo_data),
		.out_ready_in(tx_launch)
	);

	// ------------------------------------------------------------
	// Transmitter
	// ------------------------------------------------------------
	assign tx_bit_end = tx_state != lmuc_pkg::TX_IDLE && tx_cnt == '0;
	assign stop_last = tx_state == lmuc_pkg::TX_STOP && tx_bit_end &&
		tx_bits == {3'h0, two_stop_bits_in};
	assign brk_last = {1'b0, tx_bits} + 5'h01 >= {1'b0, brk_len};
	assign brk_done = tx_state == lmuc_pkg::TX_BREAK && tx_bit_end &&
		brk_last;
	// Pending break blocks the FIFO, so a synch byte waits
	assign break_go = send_break_out &&
		(tx_state == lmuc_pkg::TX_IDLE || stop_last);
	assign tx_launch = transmitter_enable_in & fifo_valid &
		~send_break_out &
		(tx_state == lmuc_pkg::TX_IDLE | stop_last);

	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			tx_state <= lmuc_pkg::TX_IDLE;
			tx_cnt <= '0;
			tx_bits <= '0;
			tx_shift <= '0;
			tx_line_out <= 1'b1;
		end else if (break_go) begin
			tx_state <= lmuc_pkg::TX_BREAK;
			tx_line_out <= 1'b0;
			tx_cnt <= bit_last;
			tx_bits <= '0;
		end else if (tx_launch) begin
			// Back to back from stop: no idle gap
			tx_state <= lmuc_pkg::TX_START;
			tx_line_out <= 1'b0;
			tx_shift <= fifo_data;
			tx_cnt <= bit_last;
			tx_bits <= '0;
		end else if (tx_bit_end) begin
			tx_cnt <= bit_last;
			unique case (tx_state)
				lmuc_pkg::TX_IDLE: begin
				end
				lmuc_pkg::TX_START: begin
					tx_state <= lmuc_pkg::TX_DATA;
					tx_line_out <= tx_shift[0];
				end
				lmuc_pkg::TX_DATA: begin
					if (tx_bits == 4'h7) begin
						tx_state <= lmuc_pkg::TX_STOP;
						tx_line_out <= 1'b1;
						tx_bits <= '0;
					end else begin
						tx_line_out <= tx_shift[1];
						tx_shift <= {1'b0, tx_shift[7:1]};
						tx_bits <= tx_bits + 4'h1;
					end
				end
				lmuc_pkg::TX_STOP: begin
					if (stop_last) begin
						tx_state <= lmuc_pkg::TX_IDLE;
					end else begin
						tx_bits <= tx_bits + 4'h1;
					end
				end
				lmuc_pkg::TX_BREAK: begin
					if (brk_last) begin
						tx_state <= lmuc_pkg::TX_IDLE;
						tx_line_out <= 1'b1;
					end else begin
						tx_bits <= tx_bits + 4'h1;
					end
				end
			endcase
		end else if (tx_state != lmuc_pkg::TX_IDLE) begin
			tx_cnt <= tx_cnt - 16'h0001;
		end
	end

	// Request wins over completion in the same cycle
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			send_break_out <= 1'b0;
		end else if (send_break_set_in) begin
			send_break_out <= 1'b1;
		end else if (brk_done) begin
			send_break_out <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			tx_en_q <= 1'b0;
			transmit_data_empty_out <= 1'b0;
			transmitter_idle_out <= 1'b1;
		end else begin
			tx_en_q <= transmitter_enable_in;
			if ((transmitter_enable_in & ~tx_en_q) |
				(tx_state == lmuc_pkg::TX_START & tx_bit_end)) begin
				transmit_data_empty_out <= 1'b1;
			end else if (push) begin
				transmit_data_empty_out <= 1'b0;
			end
			transmitter_idle_out <= tx_state == lmuc_pkg::TX_IDLE &&
				!fifo_valid && !send_break_out;
		end
	end

	// Compared at mid bit, after the bus has settled
	assign ple_hit = lin_on && tx_state != lmuc_pkg::TX_IDLE &&
		tx_cnt == bit_half && rx_line_in != tx_line_out;

	// ------------------------------------------------------------
	// Low time measurement
	// ------------------------------------------------------------
	assign fall = rx_q & ~rx_line_in;
	assign rise = ~rx_q & rx_line_in;

	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rx_q <= 1'b1;
			low_cnt <= '0;
			low_bits <= '0;
		end else begin
			rx_q <= rx_line_in;
			if (rx_line_in) begin
				low_cnt <= '0;
				low_bits <= '0;
			end else if (low_cnt == bit_last) begin
				low_cnt <= '0;
				if (low_bits != lmuc_pkg::LOW_CAP) begin
					low_bits <= low_bits + 5'h01;
				end
			end else begin
				low_cnt <= low_cnt + 16'h0001;
			end
		end
	end

	assign wake_hit = rise && lin_on &&
		lin_state_out == lmuc_pkg::LIN_SLEEP &&
		low_bits >= lmuc_pkg::WAKE_BITS;
	assign wait_hit = rise && slave &&
		lin_state_out == lmuc_pkg::LIN_WAIT &&
		low_bits >= lmuc_pkg::WAIT_BRK_BITS;
	assign act_hit = rise && slave &&
		lin_state_out == lmuc_pkg::LIN_ACTIVE &&
		low_bits >= lmuc_pkg::ACTIVE_BRK_BITS;

	// ------------------------------------------------------------
	// Control and LIN state
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			master_select <= 1'b0;
			slave_select <= 1'b0;
			autobaud_enable <= 1'b0;
			brk_len <= lmuc_pkg::BRK_LEN_RST;
			lin_state_out <= lmuc_pkg::LIN_SLEEP;
		end else if (lin_ctrl_wr_in &&
			shared_reg_select_in == lmuc_pkg::MODE_SEL_LIN) begin
			master_select <= lin_ctrl_in.master_select;
			slave_select <= lin_ctrl_in.slave_select;
			autobaud_enable <= lin_ctrl_in.autobaud_enable;
			brk_len <= lin_ctrl_in.transmit_break_length;
			// Sleep and skip-frame entered by software here
			lin_state_out <= lin_ctrl_in.lin_state_field;
		end else if (wait_hit | act_hit) begin
			lin_state_out <= lmuc_pkg::LIN_ABAUD;
		end else if (ab_done) begin
			lin_state_out <= lmuc_pkg::LIN_ACTIVE;
		end
	end

	// ------------------------------------------------------------
	// Autobaud
	// ------------------------------------------------------------
	// Falls at bits 1, 3, 5 and 7: the fourth marks 8 bit times
	assign ab_done = ab_run & fall &
		ab_edges == lmuc_pkg::ABAUD_LAST_EDGE;
	assign ab_ovf = ab_run && !ab_done &&
		ab_pre == lmuc_pkg::PRESCALE_TOP && ab_cnt == 16'hFFFF;

	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ab_run <= 1'b0;
			ab_hold <= 1'b0;
			ab_pre <= '0;
			ab_cnt <= '0;
			ab_edges <= '0;
		end else if (lin_state_out != lmuc_pkg::LIN_ABAUD) begin
			ab_run <= 1'b0;
			ab_hold <= 1'b0;
		end else if (ab_ovf) begin
			// Held idle until software rewrites the state
			ab_run <= 1'b0;
			ab_hold <= 1'b1;
		end else if (ab_done) begin
			ab_run <= 1'b0;
		end else if (ab_run) begin
			ab_pre <= ab_pre + 3'h1;
			if (ab_pre == lmuc_pkg::PRESCALE_TOP) begin
				ab_cnt <= ab_cnt + 16'h0001;
			end
			if (fall) begin
				ab_edges <= ab_edges + 2'h1;
			end
		end else if (slave && !ab_hold && fall) begin
			ab_run <= 1'b1;
			ab_pre <= '0;
			ab_cnt <= '0;
			ab_edges <= '0;
		end
	end

	// Prescaler of 8 makes the count the bit interval
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			baud_reload_out <= lmuc_pkg::BAUD_RST;
		end else if (ab_done && autobaud_enable) begin
			// Closing edge counts too, else one interval short
			baud_reload_out <= ab_cnt +
				16'(ab_pre == lmuc_pkg::PRESCALE_TOP);
		end else if (baud_reload_wr_in) begin
			baud_reload_out <= baud_reload_in;
		end
	end

	// ------------------------------------------------------------
	// Receiver
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rx_state <= lmuc_pkg::RX_IDLE;
			rx_cnt <= '0;
			rx_bits <= '0;
			rx_shift <= '0;
			rx_report <= 1'b0;
			rx_data_out <= '0;
			rx_valid_out <= 1'b0;
		end else begin
			rx_valid_out <= 1'b0;
			// Synch byte is timed, not received
			if (!receiver_enable_in ||
				lin_state_out == lmuc_pkg::LIN_ABAUD) begin
				rx_state <= lmuc_pkg::RX_IDLE;
			end else if (rx_state == lmuc_pkg::RX_IDLE) begin
				if (fall) begin
					rx_state <= lmuc_pkg::RX_START;
					rx_cnt <= bit_half;
					// Synch byte and skipped frames stay silent
					rx_report <= lin_state_out ==
						lmuc_pkg::LIN_ACTIVE;
				end
			end else if (rx_cnt != '0) begin
				rx_cnt <= rx_cnt - 16'h0001;
			end else begin
				rx_cnt <= bit_last;
				unique case (rx_state)
					lmuc_pkg::RX_IDLE: begin
					end
					lmuc_pkg::RX_START: begin
						rx_bits <= '0;
						rx_state <= rx_line_in ? lmuc_pkg::RX_IDLE :
							lmuc_pkg::RX_DATA;
					end
					lmuc_pkg::RX_DATA: begin
						rx_shift <= {rx_line_in, rx_shift[7:1]};
						rx_bits <= rx_bits + 3'h1;
						if (rx_bits == 3'h7) begin
							rx_state <= lmuc_pkg::RX_STOP;
						end
					end
					lmuc_pkg::RX_STOP: begin
						// Framing error drops the byte, covers breaks
						rx_state <= lmuc_pkg::RX_IDLE;
						if (rx_line_in && rx_report &&
							lin_state_out == lmuc_pkg::LIN_ACTIVE) begin
							rx_data_out <= rx_shift;
							rx_valid_out <= 1'b1;
						end
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Status flags, set wins over clear
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			status_out <= '0;
		end else begin
			if (wake_hit | wait_hit | act_hit) begin
				status_out.break_detect <= 1'b1;
				status_out.received_break_length <=
					low_bits > lmuc_pkg::LEN_SAT ? 4'hF :
					low_bits[3:0];
			end else if (status_clear_in) begin
				status_out.break_detect <= 1'b0;
			end
			if (ab_ovf) begin
				status_out.overrun_error <= 1'b1;
			end else if (status_clear_in) begin
				status_out.overrun_error <= 1'b0;
			end
			if (ple_hit) begin
				status_out.physical_layer_error <= 1'b1;
			end else if (status_clear_in) begin
				status_out.physical_layer_error <= 1'b0;
			end
		end
	end
endmodule

// ### testbench/lmuc_top_monitor.sv
// Purpose: Port-level checks of the LIN mode serial controller.
// Assumes: Bound to lmuc_top, one clock domain.
// Notes: State moves are tied to break lengths and control writes.

`timescale 1ns/1ps

module lmuc_top_monitor #(
	parameter int FIFO_DEPTH = 16
) (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic reset_n_in,
	// Configuration
	input wire logic [2:0] shared_reg_select_in,
	input wire logic lin_ctrl_wr_in,
	input wire lmuc_pkg::lmuc_ctrl_s lin_ctrl_in,
	input wire logic transmitter_enable_in,
	input wire logic receiver_enable_in,
	input wire logic two_stop_bits_in,
	input wire logic send_break_set_in,
	input wire logic baud_reload_wr_in,
	input wire logic [15:0] baud_reload_in,
	input wire logic status_clear_in,
	// Transmit data
	input wire logic tx_valid_in,
	input wire logic [7:0] tx_data_in,
	input wire logic tx_ready_out,
	// Bus line
	input wire logic rx_line_in,
	input wire logic tx_line_out,
	// Receive data
	input wire logic [7:0] rx_data_out,
	input wire logic rx_valid_out,
	// Status
	input wire logic transmit_data_empty_out,
	input wire logic transmitter_idle_out,
	input wire logic send_break_out,
	input wire lmuc_pkg::lmuc_lin_e lin_state_out,
	input wire lmuc_pkg::lmuc_status_s status_out,
	input wire logic [15:0] baud_reload_out
);
	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!reset_n_in);

	wire lin_wr = lin_ctrl_wr_in &&
		shared_reg_select_in == lmuc_pkg::MODE_SEL_LIN;

	a_ctrl_write_taken: assert property (lin_wr |=>
		lin_state_out == $past(lin_ctrl_in.lin_state_field))
		else $error("control write not applied");
	a_ctrl_other_sel: assert property (
		lin_ctrl_wr_in && !lin_wr && lin_state_out == lmuc_pkg::LIN_SLEEP
		|=> lin_state_out == lmuc_pkg::LIN_SLEEP)
		else $error("control write leaked through other select");
	a_break_req_seen: assert property (
		send_break_set_in |=> send_break_out)
		else $error("break request not pending");
	a_break_ends_low: assert property (
		$fell(send_break_out) |-> !$past(tx_line_out))
		else $error("break cleared without low line");
	a_enable_sets_empty: assert property (
		$rose(transmitter_enable_in) |=> transmit_data_empty_out)
		else $error("enable did not set transmit empty");
	a_rx_needs_active: assert property (rx_valid_out |->
		$past(lin_state_out) == lmuc_pkg::LIN_ACTIVE &&
		$past(receiver_enable_in))
		else $error("receive event outside active state");
	a_wait_break_len: assert property (
		$past(lin_state_out) == lmuc_pkg::LIN_WAIT &&
		lin_state_out == lmuc_pkg::LIN_ABAUD && !$past(lin_wr)
		|-> status_out.break_detect &&
		status_out.received_break_length >= 4'hB)
		else $error("wait state left on short break");
	a_active_break_len: assert property (
		$past(lin_state_out) == lmuc_pkg::LIN_ACTIVE &&
		lin_state_out == lmuc_pkg::LIN_ABAUD && !$past(lin_wr)
		|-> status_out.break_detect &&
		status_out.received_break_length >= 4'hA)
		else $error("active state left on short break");
	a_baud_source: assert property (
		baud_reload_out != $past(baud_reload_out) |->
		$past(baud_reload_wr_in) ||
		$past(lin_state_out) == lmuc_pkg::LIN_ABAUD)
		else $error("baud reload changed without cause");

	c_break_done: cover property ($fell(send_break_out));
	c_autobaud_done: cover property (
		$past(lin_state_out) == lmuc_pkg::LIN_ABAUD &&
		lin_state_out == lmuc_pkg::LIN_ACTIVE);
	c_rx_event: cover property (rx_valid_out);
endmodule

// ### testbench/lmuc_lin_node.sv
// Purpose: Other LIN node sharing the single-wire bus.
// Assumes: Open-drain bus with pull-up, released level is 1.
// Notes: Drives only on falling clock edges.

`timescale 1ns/1ps

module lmuc_lin_node (
	// Clock
	input wire logic clk_in,
	// Bus pull-down, 0 pulls the wire low
	output logic line_out
);
	initial line_out = 1'b1;

	// Breaks and wake-up pulses are plain low spans
	task automatic hold_low(input int clks);
		@(negedge clk_in);
		line_out = 1'b0;
		repeat (clks) @(negedge clk_in);
		line_out = 1'b1;
	endtask

	// LSB first, one stop bit, then one idle bit
	task automatic send_byte(input logic [7:0] b, input int r);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(negedge clk_in);
			line_out = f[i];
			repeat (r - 1) @(negedge clk_in);
		end
		repeat (r) @(negedge clk_in);
	endtask
endmodule

// ### testbench/lmuc_top_tb_top.sv
// Purpose: Self-checking bench of the LIN mode serial controller.
// Assumes: Inputs change on falling edges, outputs read there too.
// Notes: Short bit intervals keep the run brief.

`timescale 1ns/1ps

module lmuc_top_tb_top;
	localparam int R = 16;
	localparam int R2 = 24;
	logic ref_clk_in = 1'b0, reset_n_in = 1'b0;
	logic [2:0] shared_reg_select_in = 3'h0;
	logic lin_ctrl_wr_in = 1'b0, receiver_enable_in = 1'b1;
	logic transmitter_enable_in = 1'b0, two_stop_bits_in = 1'b0;
	logic send_break_set_in = 1'b0, baud_reload_wr_in = 1'b0;
	logic status_clear_in = 1'b0, tx_valid_in = 1'b0;
	logic [15:0] baud_reload_in = 16'h0000, baud_reload_out;
	logic [7:0] tx_data_in = 8'h00, rx_data_out, rx_last;
	logic tx_ready_out, tx_line_out, rx_valid_out, send_break_out;
	logic transmit_data_empty_out, transmitter_idle_out;
	lmuc_pkg::lmuc_ctrl_s lin_ctrl_in = '0;
	lmuc_pkg::lmuc_lin_e lin_state_out;
	lmuc_pkg::lmuc_status_s status_out;
	wire node_line;
	wire rx_line_in = tx_line_out & node_line;
	int err_total = 0, samples_checked = 0, rx_cnt = 0, cyc = 0;
	int low_run = 0, last_low = 0;

	lmuc_top #(.FIFO_DEPTH(16)) dut (.*);
	lmuc_lin_node node (.clk_in(ref_clk_in), .line_out(node_line));

	always #10 ref_clk_in = ~ref_clk_in;
	always @(posedge ref_clk_in) cyc <= cyc + 1;
	always @(negedge ref_clk_in) begin
		if (rx_valid_out === 1'b1) begin
			rx_cnt++;
			rx_last = rx_data_out;
		end
	end
	// Length of the last finished low span on the transmit line
	always @(negedge ref_clk_in) begin
		if (tx_line_out === 1'b0)
			low_run++;
		else if (low_run != 0) begin
			last_low = low_run;
			low_run = 0;
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic ticks(input int n);
		repeat (n) @(negedge ref_clk_in);
	endtask

	task automatic wctl(input logic [2:0] s, input logic [8:0] c);
		@(negedge ref_clk_in);
		shared_reg_select_in = s;
		lin_ctrl_in = lmuc_pkg::lmuc_ctrl_s'(c);
		lin_ctrl_wr_in = 1'b1;
		@(negedge ref_clk_in);
		lin_ctrl_wr_in = 1'b0;
		ticks(1);
	endtask

	task automatic clr();
		status_clear_in = 1'b1;
		ticks(1);
		status_clear_in = 1'b0;
		ticks(1);
	endtask

	task automatic push(input logic [7:0] b);
		int n;
		n = 0;
		@(negedge ref_clk_in);
		tx_valid_in = 1'b1;
		tx_data_in = b;
		while (tx_ready_out !== 1'b1 && n < 5000) begin
			n++;
			ticks(1);
		end
		ticks(1);
		tx_valid_in = 1'b0;
	endtask

	task automatic get_frame(input int r, output logic [7:0] b,
		output int t);
		int n;
		n = 0;
		while (tx_line_out !== 1'b0 && n < 20000) begin
			n++;
			ticks(1);
		end
		t = cyc;
		ticks(r / 2);
		for (int i = 0; i < 8; i++) begin
			ticks(r);
			b[i] = tx_line_out;
		end
		ticks(r);
		check(16'(tx_line_out), 16'h0001);
	endtask

	initial begin
		repeat (60000) @(posedge ref_clk_in);
		err_total++;
		$display("ERROR %0t: watchdog expired", $time);
		give_verdict();
	end

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		int t0, t1;
		logic [7:0] b;
		ticks(12);
		reset_n_in = 1'b1;
		ticks(2);
		check(16'(tx_line_out), 16'h0001);
		check(16'(lin_state_out), 16'h0000);
		check(baud_reload_out, lmuc_pkg::BAUD_RST);
		$display("test reset done");
		// Master, state 11, break length 13
		wctl(3'h0, 9'h13D);
		check(16'(lin_state_out), 16'h0000);
		wctl(lmuc_pkg::MODE_SEL_LIN, 9'h13D);
		check(16'(lin_state_out), 16'h0003);
		baud_reload_in = 16'(R);
		baud_reload_wr_in = 1'b1;
		ticks(1);
		baud_reload_wr_in = 1'b0;
		ticks(1);
		check(baud_reload_out, 16'(R));
		transmitter_enable_in = 1'b1;
		ticks(2);
		check(16'(transmit_data_empty_out), 16'h0001);
		$display("test control done");
		send_break_set_in = 1'b1;
		ticks(1);
		send_break_set_in = 1'b0;
		push(8'h55);
		check(16'(send_break_out), 16'h0001);
		check(16'(transmit_data_empty_out), 16'h0000);
		while (send_break_out === 1'b1) ticks(1);
		ticks(1);
		check(16'(last_low), 16'(13 * R));
		get_frame(R, b, t0);
		check(16'(b), 16'h0055);
		check(16'(last_low), 16'(R));
		$display("test break done");
		push(8'hA5);
		push(8'h3C);
		get_frame(R, b, t0);
		check(16'(b), 16'h00A5);
		get_frame(R, b, t1);
		check(16'(b), 16'h003C);
		check(16'(t1 - t0), 16'(10 * R));
		two_stop_bits_in = 1'b1;
		push(8'h0F);
		push(8'hF0);
		get_frame(R, b, t0);
		get_frame(R, b, t1);
		check(16'(b), 16'h00F0);
		check(16'(t1 - t0), 16'(11 * R));
		ticks(2 * R);
		check(16'(rx_cnt), 16'h0005);
		check(16'(rx_last), 16'h00F0);
		receiver_enable_in = 1'b0;
		push(8'h81);
		get_frame(R, b, t0);
		ticks(R);
		check(16'(rx_cnt), 16'h0005);
		receiver_enable_in = 1'b1;
		push(8'hFF);
		while (tx_line_out !== 1'b0) ticks(1);
		ticks(2 * R);
		node.hold_low(R);
		ticks(2);
		check(16'(status_out.physical_layer_error), 16'h0001);
		ticks(8 * R);
		clr();
		check(16'(status_out.physical_layer_error), 16'h0000);
		$display("test frames done");
		transmitter_enable_in = 1'b0;
		for (int i = 0; i < 16; i++) push(8'(i));
		ticks(2);
		check(16'(tx_ready_out), 16'h0000);
		transmitter_enable_in = 1'b1;
		for (int n = 0; n < 180 * R && transmitter_idle_out !== 1'b1; n++)
			ticks(1);
		check(16'(transmitter_idle_out), 16'h0001);
		check(16'(transmit_data_empty_out), 16'h0001);
		$display("test fifo done");
		wctl(lmuc_pkg::MODE_SEL_LIN, 9'h10D);
		clr();
		node.hold_low(2 * R + R / 2);
		ticks(3);
		check(16'(status_out.break_detect), 16'h0000);
		node.hold_low(4 * R + R / 2);
		ticks(3);
		check(16'(status_out.break_detect), 16'h0001);
		check(16'(status_out.received_break_length), 16'h0004);
		clr();
		node.hold_low(12500);
		ticks(3);
		check(16'(status_out.received_break_length), 16'h000F);
		$display("test sleep done");
		wctl(lmuc_pkg::MODE_SEL_LIN, 9'h0DD);
		clr();
		node.hold_low(10 * R + R / 2);
		ticks(3);
		check(16'(lin_state_out), 16'h0001);
		check(16'(status_out.break_detect), 16'h0000);
		node.hold_low(12 * R + R / 2);
		ticks(3);
		check(16'(lin_state_out), 16'h0002);
		check(16'(status_out.received_break_length), 16'h000C);
		node.send_byte(8'h55, R2);
		check(16'(lin_state_out), 16'h0003);
		check(baud_reload_out, 16'(R2));
		t0 = rx_cnt;
		node.send_byte(8'hA5, R2);
		check(16'(rx_cnt - t0), 16'h0001);
		check(16'(rx_last), 16'h00A5);
		wctl(lmuc_pkg::MODE_SEL_LIN, 9'h0DD);
		node.send_byte(8'h3C, R2);
		check(16'(rx_cnt - t0), 16'h0001);
		node.hold_low(12 * R2 + R2 / 2);
		ticks(3);
		node.send_byte(8'h55, R2);
		check(16'(lin_state_out), 16'h0003);
		node.hold_low(10 * R2 + R2 / 2);
		ticks(3);
		check(16'(lin_state_out), 16'h0002);
		check(16'(status_out.received_break_length), 16'h000A);
		$display("test slave done");
		give_verdict();
	end
endmodule

bind lmuc_top lmuc_top_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) u_mon (.*);
